// file: inc/lvdc_defs.svh
`ifndef LVDC_DEFS_SVH
`define LVDC_DEFS_SVH

// ----------------------------------------------------------------------------
// Reset vector
// ----------------------------------------------------------------------------
`define LVDC_RESET_VEC_HI 16'hfffe
`define LVDC_RESET_VEC_LO 16'hffff

// ----------------------------------------------------------------------------
// Reset source status bit positions and values
// ----------------------------------------------------------------------------
`define LVDC_SRS_POR_BIT 7
`define LVDC_SRS_PIN_BIT 6
`define LVDC_SRS_WDOG_BIT 5
`define LVDC_SRS_ILOP_BIT 4
`define LVDC_SRS_ILAD_BIT 3
`define LVDC_SRS_LOC_BIT 2
`define LVDC_SRS_LVR_BIT 1
`define LVDC_SRS_RESET_VAL 8'h82

// ----------------------------------------------------------------------------
// Cause priority vector bit positions
// ----------------------------------------------------------------------------
`define LVDC_CAUSE_W 8
`define LVDC_CAUSE_WDOG 0
`define LVDC_CAUSE_LOC 1
`define LVDC_CAUSE_LVR 2
`define LVDC_CAUSE_PIN 3
`define LVDC_CAUSE_ILOP 4
`define LVDC_CAUSE_ILAD 5
`define LVDC_CAUSE_POR 6
`define LVDC_CAUSE_DBG 7

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define LVDC_SYNC_STAGES 2

`endif

// file: inc/lvdc_pkg.sv
package lvdc_pkg;

  // Stop mode granted to the power controller.
  typedef enum logic [1:0] {
    LVDC_RUN = 2'b00,
    LVDC_LIGHT_STOP = 2'b01,
    LVDC_DEEP_STOP = 2'b11
  } lvdc_stop_e;

  // Reset sequencer states, Gray coded along hold -> run -> hold.
  typedef enum logic [1:0] {
    LVDC_HOLD = 2'b00,
    LVDC_RUNNING = 2'b01,
    LVDC_LVHOLD = 2'b11
  } lvdc_state_e;

endpackage

// file: verilog/lvdc_sync.sv
`timescale 1ns/1ps

module lvdc_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clock, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic [WIDTH-1:0] rawLevels, // Raw comparator levels.
  output logic [WIDTH-1:0] stableLevels // Synchronised levels.
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } lvdc_sync_s;

  lvdc_sync_s state_reg;
  lvdc_sync_s state_next;
  logic [WIDTH-1:0] metaNext;
  logic [WIDTH-1:0] stableNext;

  // --------------------------------------------------------------------------
  // Two flop chain per bit
  // --------------------------------------------------------------------------
  // Each bit gets its own pair; only the second flop is ever read downstream.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      assign metaNext[i] = rawLevels[i];
      assign stableNext[i] = state_reg.meta[i];
    end
  endgenerate

  // Gather the per-bit values into the one next-state copy.
  always_comb begin
    state_next.meta = metaNext;
    state_next.stable = stableNext;
  end

  // Register the chain.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign stableLevels = state_reg.stable;

endmodule

// file: verilog/lvdc_control.sv
`timescale 1ns/1ps
`include "lvdc_defs.svh"

// How it works
// - Detector active only while detect enable set.
// - Stop turns detector off unless stop enable.
// - Both enables turn deep stop into light.
// - After power-on, hold reset until supply good.
// - Power-on sets power-on and low-voltage status.
// - Reset enable plus low voltage forces reset.
// - Low-voltage reset holds until above threshold.
// - Warning with enable sets flag, requests interrupt.
// - All resets share vector, highest priority.
// - Flag requests interrupt only while enabled.
module lvdc_control (
  input wire logic clock, // System clock, 250 MHz.
  input wire logic rst, // Power-on reset, asynchronous, active high.
  input wire logic lowVoltageDetectEnable, // Detector enable.
  input wire logic lowVoltageStopEnable, // Keep detector running in stop.
  input wire logic lowVoltageResetEnable, // Low voltage forces a reset.
  input wire logic lowVoltageThresholdSelect, // 0 low trip, 1 high trip.
  input wire logic lowVoltageWarningIrqEnable, // Warning interrupt enable.
  input wire logic warnFlagClear, // Pulse: acknowledge warning flag.
  input wire logic belowLowTrip, // Analog: supply below low threshold.
  input wire logic belowHighTrip, // Analog: supply below high threshold.
  input wire logic warnCompare, // Analog: supply approaching low voltage.
  input wire logic stopRequest, // Processor asks to enter stop.
  input wire logic deepStopSelect, // Requested stop is deep stop.
  input wire logic wakeup, // Leave stop mode.
  input wire logic [`LVDC_CAUSE_W-1:0] otherResetCause, // Other reset sources.
  output logic [1:0] stopMode, // Granted stop mode, lvdc_stop_e coding.
  output logic detectorPowered, // Analog detector power enable.
  output logic cpuReset, // Processor held in reset.
  output logic [15:0] vectorAddr, // Vector fetch address, high byte.
  output logic [7:0] resetSourceStatus, // Reset source status byte.
  output logic lowVoltageWarningFlag, // Sticky warning flag.
  output logic warnIrq // Warning interrupt request.
);
  import lvdc_pkg::*;

  typedef struct packed {
    lvdc_state_e seq;
    lvdc_stop_e stop;
    logic powered;
    logic cpuRst;
    logic [1:0] settle;
    logic [15:0] vec;
    logic [7:0] reset_source_status;
    logic warnFlag;
    logic irq;
  } lvdc_state_s;

  lvdc_state_s state_reg;
  lvdc_state_s state_next;
  logic [2:0] syncLevels;
  logic lowSync;
  logic highSync;
  logic warnSync;
  logic tripSync;
  logic detectOn;
  logic [`LVDC_CAUSE_W-1:0] causes;

  // --------------------------------------------------------------------------
  // Comparator synchroniser
  // --------------------------------------------------------------------------
  // synchronise analog levels
  lvdc_sync #(
    .WIDTH(3)
  ) u_sync (
    .clock(clock),
    .rst(rst),
    .rawLevels({warnCompare, belowHighTrip, belowLowTrip}),
    .stableLevels(syncLevels)
  );

  assign lowSync = syncLevels[0];
  assign highSync = syncLevels[1];
  assign warnSync = syncLevels[2];

  // --------------------------------------------------------------------------
  // Detector gating
  // --------------------------------------------------------------------------
  // Results from an unpowered detector are ignored, so a stale comparator
  // level left over after stop entry cannot raise a reset.
  always_comb begin
    tripSync = lowVoltageThresholdSelect ? highSync : lowSync;
    detectOn = lowVoltageDetectEnable &&
               (state_reg.stop == LVDC_RUN || lowVoltageStopEnable);
  end

  // Cause vector, low vector index is lowest priority.
  always_comb begin
    causes = otherResetCause;
    causes[`LVDC_CAUSE_LVR] = detectOn && lowVoltageResetEnable && tripSync;
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.powered = detectOn;

    // Stop mode arbitration.
    if (state_reg.stop == LVDC_RUN) begin
      if (stopRequest && !state_reg.cpuRst) begin
        if (deepStopSelect && !(lowVoltageDetectEnable && lowVoltageStopEnable)) begin
          state_next.stop = LVDC_DEEP_STOP;
        end else begin
          state_next.stop = LVDC_LIGHT_STOP;
        end
      end
    end else if (wakeup || causes != '0) begin
      state_next.stop = LVDC_RUN;
    end

    // Reset sequencer.
    unique case (state_reg.seq)
      LVDC_HOLD: begin
        state_next.cpuRst = 1'b1;
        // The synchroniser clears on power-on, so its first outputs say nothing
        // about the supply; wait until the chain has been refilled.
        if (state_reg.settle != 2'(`LVDC_SYNC_STAGES)) begin
          state_next.settle = state_reg.settle + 2'h1;
        end
        if (!lowSync && otherResetCause == '0 &&
            state_reg.settle == 2'(`LVDC_SYNC_STAGES)) begin
          state_next.seq = LVDC_RUNNING;
          state_next.cpuRst = 1'b0;
        end
      end
      LVDC_RUNNING: begin
        if (causes != '0) begin
          state_next.cpuRst = 1'b1;
          state_next.stop = LVDC_RUN;
          state_next.vec = `LVDC_RESET_VEC_HI;
          state_next.reset_source_status = '0;
          state_next.reset_source_status[`LVDC_SRS_WDOG_BIT] = causes[`LVDC_CAUSE_WDOG];
          state_next.reset_source_status[`LVDC_SRS_LOC_BIT] = causes[`LVDC_CAUSE_LOC];
          state_next.reset_source_status[`LVDC_SRS_PIN_BIT] = causes[`LVDC_CAUSE_PIN];
          state_next.reset_source_status[`LVDC_SRS_ILOP_BIT] = causes[`LVDC_CAUSE_ILOP];
          state_next.reset_source_status[`LVDC_SRS_ILAD_BIT] = causes[`LVDC_CAUSE_ILAD];
          // A low-voltage reset leaves the power-on bit as it was; every
          // other cause rewrites it.
          state_next.reset_source_status[`LVDC_SRS_POR_BIT] = causes[`LVDC_CAUSE_POR] ||
              (causes[`LVDC_CAUSE_LVR] && state_reg.reset_source_status[`LVDC_SRS_POR_BIT]);
          state_next.reset_source_status[`LVDC_SRS_LVR_BIT] = causes[`LVDC_CAUSE_LVR] ||
                                              causes[`LVDC_CAUSE_POR];
          // A debug-forced reset leaves every status bit clear.
          if (causes[`LVDC_CAUSE_DBG]) begin
            state_next.reset_source_status = '0;
          end
          state_next.seq = LVDC_LVHOLD;
        end
      end
      LVDC_LVHOLD: begin
        if (!(detectOn && lowVoltageResetEnable && tripSync) &&
            otherResetCause == '0) begin
          state_next.seq = LVDC_RUNNING;
          state_next.cpuRst = 1'b0;
        end
      end
      default: begin
        state_next.seq = LVDC_HOLD;
        state_next.cpuRst = 1'b1;
      end
    endcase

    // Warning flag; a new warning beats a same-cycle acknowledge.
    if (warnFlagClear) begin
      state_next.warnFlag = 1'b0;
    end
    if (detectOn && warnSync && lowVoltageWarningIrqEnable) begin
      state_next.warnFlag = 1'b1;
    end
    state_next.irq = state_next.warnFlag && lowVoltageWarningIrqEnable &&
                     !state_next.cpuRst;
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  // Power-on reset loads the power-on status and holds the processor.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg.seq <= LVDC_HOLD;
      state_reg.stop <= LVDC_RUN;
      state_reg.powered <= 1'b0;
      state_reg.cpuRst <= 1'b1;
      state_reg.settle <= 2'h0;
      state_reg.vec <= `LVDC_RESET_VEC_HI;
      state_reg.reset_source_status <= `LVDC_SRS_RESET_VAL;
      state_reg.warnFlag <= 1'b0;
      state_reg.irq <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Every output is a bare copy of a state flop, so the processor side never
  // sees a glitch while the next state settles.
  assign stopMode = state_reg.stop;
  assign detectorPowered = state_reg.powered;
  assign cpuReset = state_reg.cpuRst;
  assign vectorAddr = state_reg.vec;
  assign resetSourceStatus = state_reg.reset_source_status;
  assign lowVoltageWarningFlag = state_reg.warnFlag;
  assign warnIrq = state_reg.irq;

endmodule

// file: verif/lvdc_control_sva.sv
`timescale 1ns/1ps
`include "lvdc_defs.svh"
// ----------------------
// Port checker
// ----------------------
module lvdc_control_sva (
  input wire logic clock, // Clock.
  input wire logic rst, // Reset.
  input wire logic lowVoltageDetectEnable, // In.
  input wire logic lowVoltageStopEnable, // In.
  input wire logic lowVoltageResetEnable, // In.
  input wire logic lowVoltageWarningIrqEnable, // In.
  input wire logic belowLowTrip, // In.
  input wire logic warnCompare, // In.
  input wire logic stopRequest, // In.
  input wire logic deepStopSelect, // In.
  input wire logic [`LVDC_CAUSE_W-1:0] otherResetCause, // In.
  input wire logic [1:0] stopMode, // Out.
  input wire logic detectorPowered, // Out.
  input wire logic cpuReset, // Out.
  input wire logic [7:0] resetSourceStatus, // Out.
  input wire logic lowVoltageWarningFlag, // Out.
  input wire logic warnIrq // Out.
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Windows are four samples long so the two-flop synchroniser has settled.
  sequence lowHeld;
    belowLowTrip [*4];
  endsequence
  sequence deepAsk;
    stopMode == 2'h0 && stopRequest && deepStopSelect && !cpuReset && !lowVoltageResetEnable
      && otherResetCause == 8'h00;
  endsequence
  a_det_gated: assert property (detectorPowered |-> $past(lowVoltageDetectEnable))
    else $error("detector on while disabled");
  a_stop_off: assert property (($past(stopMode) != 2'h0 && !$past(lowVoltageStopEnable))
    |-> !detectorPowered) else $error("detector on in stop");
  a_deep_swap: assert property (deepAsk |=> stopMode ==
    ($past(lowVoltageDetectEnable && lowVoltageStopEnable) ? 2'h1 : 2'h3))
    else $error("wrong stop mode");
  a_hold_low: assert property (lowHeld ##0 cpuReset |=> cpuReset)
    else $error("reset released while low");
  a_release_cause: assert property ($fell(cpuReset) |-> $past(otherResetCause) == 8'h00)
    else $error("reset released with cause");
  a_por_status: assert property ($past(rst) |-> resetSourceStatus == `LVDC_SRS_RESET_VAL)
    else $error("power-on status wrong");
  a_lv_reset: assert property ((lowVoltageDetectEnable && lowVoltageResetEnable
    && belowLowTrip && stopMode == 2'h0) [*4] |-> ##[0:2] cpuReset)
    else $error("no low-voltage reset");
  a_warn_set: assert property ((warnCompare && lowVoltageWarningIrqEnable
    && lowVoltageDetectEnable && stopMode == 2'h0 && !cpuReset) [*4]
    |-> ##[0:2] lowVoltageWarningFlag) else $error("warning flag not set");
  a_irq_gate: assert property (warnIrq
    |-> lowVoltageWarningFlag && $past(lowVoltageWarningIrqEnable) && !cpuReset)
    else $error("request without enabled flag");
endmodule

bind lvdc_control lvdc_control_sva u_sva (.clock, .rst, .lowVoltageDetectEnable,
  .lowVoltageStopEnable, .lowVoltageResetEnable, .lowVoltageWarningIrqEnable, .belowLowTrip,
  .warnCompare, .stopRequest, .deepStopSelect, .otherResetCause, .stopMode, .detectorPowered,
  .cpuReset, .resetSourceStatus, .lowVoltageWarningFlag, .warnIrq);

// file: verif/lvdc_cpu_model.sv
`timescale 1ns/1ps
// ----------------------
// Core side model
// ----------------------
module lvdc_cpu_model (
  input wire logic clock, // Clock.
  input wire logic cpuReset, // Core held in reset.
  input wire logic warnIrq, // Warning request.
  input wire logic [1:0] cmd, // 1 light, 2 deep, 3 wake.
  input wire logic [3:0] ackDelay, // Handler latency in cycles.
  output logic stopRequest = 1'b0, // Stop request.
  output logic deepStopSelect = 1'b0, // Deep stop wanted.
  output logic wakeup = 1'b0, // Wake event.
  output logic warnFlagClear = 1'b0 // Flag acknowledge.
);
  logic [3:0] waitCount = 4'h0;
  // A core in reset runs no code, so it requests no stop; the handler
  // acknowledges only after its latency, which may be slow.
  always @(negedge clock) begin
    stopRequest <= !cpuReset && (cmd == 2'h1 || cmd == 2'h2);
    deepStopSelect <= cmd == 2'h2;
    wakeup <= cmd == 2'h3;
    warnFlagClear <= warnIrq && waitCount == ackDelay;
    waitCount <= (warnIrq && waitCount != ackDelay) ? waitCount + 4'h1 : 4'h0;
  end
endmodule

// file: verif/lvdc_control_bench.sv
`timescale 1ns/1ps
// ----------------------
// Bench
// ----------------------
module lvdc_control_bench;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic lowVoltageDetectEnable = 1'b0, lowVoltageStopEnable = 1'b0;
  logic lowVoltageResetEnable = 1'b0, lowVoltageThresholdSelect = 1'b0;
  logic lowVoltageWarningIrqEnable = 1'b0, warnCompare = 1'b0;
  logic belowLowTrip = 1'b1, belowHighTrip = 1'b1;
  logic [7:0] otherResetCause = 8'h00;
  logic [1:0] cmd = 2'h0;
  logic [3:0] ackDelay = 4'h2;
  logic stopRequest, deepStopSelect, wakeup, warnFlagClear, detectorPowered, cpuReset;
  logic lowVoltageWarningFlag, warnIrq;
  logic [1:0] stopMode;
  logic [15:0] vectorAddr;
  logic [7:0] resetSourceStatus;
  int bad_count = 0;
  int total_checks = 0;
  int seed;

  // Clock at 250 MHz.
  always #2 clock = ~clock;

  lvdc_control dut (.clock, .rst, .lowVoltageDetectEnable, .lowVoltageStopEnable,
    .lowVoltageResetEnable, .lowVoltageThresholdSelect, .lowVoltageWarningIrqEnable,
    .warnFlagClear, .belowLowTrip, .belowHighTrip, .warnCompare, .stopRequest,
    .deepStopSelect, .wakeup, .otherResetCause, .stopMode, .detectorPowered, .cpuReset,
    .vectorAddr, .resetSourceStatus, .lowVoltageWarningFlag, .warnIrq);
  lvdc_cpu_model cpu (.clock, .cpuReset, .warnIrq, .cmd, .ackDelay, .stopRequest,
    .deepStopSelect, .wakeup, .warnFlagClear);

  // Compare and count; case inequality so unknowns never match.
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask

  // Bounded wait for the core to leave reset.
  task automatic waitRelease;
    for (int n = 0; n < 20 && cpuReset !== 1'b0; n++) @(negedge clock);
    check("release", cpuReset, 1'b0);
  endtask

  // Deep stop becomes light while the detector must stay awake.
  function automatic logic [1:0] expStop(input logic det, input logic stp, input logic deep);
    return (deep && !(det && stp)) ? 2'h3 : 2'h1;
  endfunction

  // Status for one active cause, indexed by cause bit.
  function automatic logic [7:0] expStatus(input int idx);
    logic [7:0] map [8] = '{8'h20, 8'h04, 8'h00, 8'h40, 8'h10, 8'h08, 8'h82, 8'h00};
    return map[idx];
  endfunction

  task automatic wrap_up;
    $display("Checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // The tests need under 1000 cycles; this limit leaves wide margin.
  initial begin
    #20000;
    bad_count++;
    wrap_up;
  end

  initial begin
    seed = $urandom(32'hb65f956d);
    idle(5);
    check("por status", resetSourceStatus, 8'h82);
    rst = 1'b0;
    idle(10);
    check("por hold", cpuReset, 1'b1);
    belowLowTrip = 1'b0;
    belowHighTrip = 1'b0;
    waitRelease;
    check("por status kept", resetSourceStatus, 8'h82);
    $display("Test power-on done");
    // A watchdog reset first clears the power-on bit, so the low-voltage
    // status below must really be rewritten.
    otherResetCause = 8'h01;
    idle(3);
    check("wdog status", resetSourceStatus, expStatus(0));
    otherResetCause = 8'h00;
    waitRelease;
    lowVoltageDetectEnable = 1'b1;
    lowVoltageResetEnable = 1'b1;
    for (int sel = 0; sel < 2; sel++) begin
      lowVoltageThresholdSelect = sel[0];
      belowHighTrip = 1'b1;
      idle(6);
      check("high trip", cpuReset, sel[0]);
      belowLowTrip = 1'b1;
      idle(6);
      check("lv reset", cpuReset, 1'b1);
      check("lv status", resetSourceStatus, 8'h02);
      belowLowTrip = 1'b0;
      idle(10);
      check("lv hold", cpuReset, sel[0]);
      belowHighTrip = 1'b0;
      waitRelease;
    end
    $display("Test low-voltage reset done");
    lowVoltageDetectEnable = 1'b0;
    lowVoltageWarningIrqEnable = 1'b1;
    {belowLowTrip, belowHighTrip, warnCompare} = 3'h7;
    idle(10);
    check("off reset", cpuReset, 1'b0);
    check("off flag", lowVoltageWarningFlag, 1'b0);
    check("off power", detectorPowered, 1'b0);
    {belowLowTrip, belowHighTrip, warnCompare} = 3'h0;
    lowVoltageResetEnable = 1'b0;
    idle(4);
    $display("Test detector off done");
    for (int k = 0; k < 8; k++) begin
      {lowVoltageStopEnable, lowVoltageDetectEnable} = k[1:0];
      cmd <= k[2] ? 2'h2 : 2'h1;
      idle(1);
      cmd <= 2'h0;
      idle(3);
      check("stop mode", stopMode, expStop(k[0], k[1], k[2]));
      check("stop power", detectorPowered, k[0] && k[1]);
      cmd <= 2'h3;
      idle(1);
      cmd <= 2'h0;
      idle(3);
      check("woken", stopMode, 2'h0);
    end
    $display("Test stop modes done");
    lowVoltageDetectEnable = 1'b1;
    for (int r = 0; r < 4; r++) begin
      lowVoltageWarningIrqEnable = (r == 0) ? 1'b1 : 1'($urandom_range(1, 0));
      ackDelay <= (r == 0) ? 4'hf : 4'($urandom_range(15, 0));
      warnCompare = 1'b1;
      idle(6);
      check("warn flag", lowVoltageWarningFlag, lowVoltageWarningIrqEnable);
      check("warn irq", warnIrq, lowVoltageWarningIrqEnable);
      warnCompare = 1'b0;
      lowVoltageWarningIrqEnable = (r == 0) ? 1'b0 : lowVoltageWarningIrqEnable;
      idle(3);
      if (r == 0) check("polled irq", warnIrq, 1'b0);
      if (r == 0) check("polled flag", lowVoltageWarningFlag, 1'b1);
      lowVoltageWarningIrqEnable = 1'b1;
      idle(22);
      check("flag cleared", lowVoltageWarningFlag, 1'b0);
    end
    $display("Test warning done");
    for (int i = 0; i < 8; i++) begin
      if (i == 2) continue;
      otherResetCause = 8'h01 << i;
      idle(3);
      check("cause reset", cpuReset, 1'b1);
      check("cause status", resetSourceStatus, expStatus(i));
      check("vector", vectorAddr, 16'hfffe);
      otherResetCause = 8'h00;
      waitRelease;
    end
    $display("Test reset causes done");
    rst = 1'b1;
    idle(2);
    check("rearm status", resetSourceStatus, 8'h82);
    rst = 1'b0;
    idle(1);
    check("rearm hold", cpuReset, 1'b1);
    waitRelease;
    $display("Test second power-on done");
    wrap_up;
  end
endmodule
